// >>> src/pief_bank.sv
// Module: interrupt enable registers, request flags and forwarding to the core.
//
// Implementation choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module pief_bank #(
  parameter int EXT_EN_WIDTH = 24
) (
  input  wire logic                     clk,
  input  wire logic                     sys_rst,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  input  wire pief_pkg::pief_events_type events,
  input  wire logic                     portChangeFlags,
  input  wire logic [EXT_EN_WIDTH-1:0]  extPeriphPending,
  output logic                          periphReq,
  output logic                          vectorReq,
  output logic                          irq
);

  initial begin
    if (EXT_EN_WIDTH < 1) begin
      $error("EXT_EN_WIDTH must be at least one");
    end
  end

  pief_pkg::pief_state_type state;
  pief_pkg::pief_state_type next_state;

  logic       wrStrobe;
  logic       rdStrobe;
  logic [7:0] wByte;
  logic [7:0] flg0View;
  logic       periphPend;
  logic       en0Pend;
  logic       gieOn;
  logic       peieOn;
  logic       addrMapped;

  // ****************************************************************
  // Pending terms
  // ****************************************************************
  // Timer0 and external edge are vectored through enable 0; the pin-change summary too.
  always_comb begin
    flg0View   = state.flg0;
    flg0View[pief_pkg::PIEF_BIT_PINCHG] = portChangeFlags;
    gieOn      = state.ctrl[pief_pkg::PIEF_BIT_GIE];
    peieOn     = state.ctrl[pief_pkg::PIEF_BIT_PERIPH_MASTER_ENABLE];
    en0Pend    = |(flg0View & state.en0);
    periphPend = (|(state.flg1 & state.en1)) | (|(state.flg2 & state.en2))
               | (|extPeriphPending);
    case (paddr)
      pief_pkg::PIEF_ADDR_CTRL, pief_pkg::PIEF_ADDR_EN0, pief_pkg::PIEF_ADDR_EN1,
      pief_pkg::PIEF_ADDR_EN2, pief_pkg::PIEF_ADDR_EN5, pief_pkg::PIEF_ADDR_EN6,
      pief_pkg::PIEF_ADDR_EN7, pief_pkg::PIEF_ADDR_EN8, pief_pkg::PIEF_ADDR_FLG0,
      pief_pkg::PIEF_ADDR_FLG1, pief_pkg::PIEF_ADDR_FLG2, pief_pkg::PIEF_ADDR_IRQSTAT,
      pief_pkg::PIEF_ADDR_IRQEN, pief_pkg::PIEF_ADDR_IRQCLR: addrMapped = 1'b1;
      default: addrMapped = 1'b0;
    endcase
  end

  assign wrStrobe = psel && penable && pwrite && state.pready;
  assign rdStrobe = psel && !penable && !pwrite;
  assign wByte    = pwdata[7:0];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    next_state = state;
    // One wait state: pready rises in the second access cycle, the write lands there.
    next_state.pready  = psel && penable && !state.pready;
    // The error is decoded one cycle ahead so that it stands together with pready.
    next_state.pslverr = psel && penable && pwrite && !state.pready && !addrMapped;
    if (wrStrobe) begin
      case (paddr)
        pief_pkg::PIEF_ADDR_CTRL:  next_state.ctrl = wByte & pief_pkg::PIEF_MASK_CTRL;
        pief_pkg::PIEF_ADDR_EN0:   next_state.en0  = wByte & pief_pkg::PIEF_MASK_EN0;
        pief_pkg::PIEF_ADDR_EN1:   next_state.en1  = wByte & pief_pkg::PIEF_MASK_EN1;
        pief_pkg::PIEF_ADDR_EN2:   next_state.en2  = wByte & pief_pkg::PIEF_MASK_EN2;
        pief_pkg::PIEF_ADDR_EN5:   next_state.en5  = wByte & pief_pkg::PIEF_MASK_EN5;
        pief_pkg::PIEF_ADDR_EN6:   next_state.en6  = wByte & pief_pkg::PIEF_MASK_EN6;
        pief_pkg::PIEF_ADDR_EN7:   next_state.en7  = wByte & pief_pkg::PIEF_MASK_EN7;
        pief_pkg::PIEF_ADDR_EN8:   next_state.en8  = wByte & pief_pkg::PIEF_MASK_EN8;
        // The summary bit is never stored; only the sticky bits take the write.
        pief_pkg::PIEF_ADDR_FLG0:  next_state.flg0 = wByte & pief_pkg::PIEF_MASK_FLG0 & 8'hEF;
        pief_pkg::PIEF_ADDR_FLG1:  next_state.flg1 = wByte & pief_pkg::PIEF_MASK_FLG1;
        pief_pkg::PIEF_ADDR_FLG2:  next_state.flg2 = wByte & pief_pkg::PIEF_MASK_FLG2;
        pief_pkg::PIEF_ADDR_IRQEN: next_state.irqEn = wByte[1:0];
        pief_pkg::PIEF_ADDR_IRQCLR: next_state.irqStat = state.irqStat & ~wByte[1:0];
        pief_pkg::PIEF_ADDR_IRQSTAT: next_state.irqStat = state.irqStat;
        default: next_state.ctrl = state.ctrl;
      endcase
    end
    // Hardware sets come after the write so that a set in the clearing cycle wins.
    if (events.timer0Ovf)     next_state.flg0[5] = 1'b1;
    if (events.extEdge)       next_state.flg0[0] = 1'b1;
    if (events.oscFail)       next_state.flg1[7] = 1'b1;
    if (events.clkSwitchDone) next_state.flg1[6] = 1'b1;
    if (events.convThreshold) next_state.flg1[1] = 1'b1;
    if (events.convDone)      next_state.flg1[0] = 1'b1;
    if (events.zeroCross)     next_state.flg2[6] = 1'b1;
    if (events.comp2)         next_state.flg2[1] = 1'b1;
    if (events.comp1)         next_state.flg2[0] = 1'b1;
    next_state.periphReq = periphPend;
    next_state.vectorReq = gieOn && (en0Pend || (peieOn && periphPend));
    if (next_state.vectorReq && !state.vectorReq) begin
      next_state.irqStat = next_state.irqStat | pief_pkg::PIEF_EVT_VEC;
    end
    if (next_state.periphReq && !state.periphReq) begin
      next_state.irqStat = next_state.irqStat | pief_pkg::PIEF_EVT_REQ;
    end
    next_state.irq = |(next_state.irqStat & next_state.irqEn);
    if (rdStrobe) begin
      case (paddr)
        pief_pkg::PIEF_ADDR_CTRL:    next_state.prdata = {24'h000000, state.ctrl};
        pief_pkg::PIEF_ADDR_EN0:     next_state.prdata = {24'h000000, state.en0};
        pief_pkg::PIEF_ADDR_EN1:     next_state.prdata = {24'h000000, state.en1};
        pief_pkg::PIEF_ADDR_EN2:     next_state.prdata = {24'h000000, state.en2};
        pief_pkg::PIEF_ADDR_EN5:     next_state.prdata = {24'h000000, state.en5};
        pief_pkg::PIEF_ADDR_EN6:     next_state.prdata = {24'h000000, state.en6};
        pief_pkg::PIEF_ADDR_EN7:     next_state.prdata = {24'h000000, state.en7};
        pief_pkg::PIEF_ADDR_EN8:     next_state.prdata = {24'h000000, state.en8};
        pief_pkg::PIEF_ADDR_FLG0:    next_state.prdata = {24'h000000, flg0View};
        pief_pkg::PIEF_ADDR_FLG1:    next_state.prdata = {24'h000000, state.flg1};
        pief_pkg::PIEF_ADDR_FLG2:    next_state.prdata = {24'h000000, state.flg2};
        pief_pkg::PIEF_ADDR_IRQSTAT: next_state.prdata = {30'h00000000, state.irqStat};
        pief_pkg::PIEF_ADDR_IRQEN:   next_state.prdata = {30'h00000000, state.irqEn};
        default:                     next_state.prdata = 32'h00000000;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign prdata    = state.prdata;
  assign pready    = state.pready;
  assign pslverr   = state.pslverr;
  assign periphReq = state.periphReq;
  assign vectorReq = state.vectorReq;
  assign irq       = state.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  master_gate_a: assert property (@(posedge clk) disable iff (sys_rst)
    (!$past(state.ctrl[pief_pkg::PIEF_BIT_PERIPH_MASTER_ENABLE]) && !$past(en0Pend)) |-> !vectorReq)
    else $error("vector raised without master enable");
  flag_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    events.comp1 |=> state.flg2[0])
    else $error("comparator 1 flag not set");
  summary_or_a: assert property (@(posedge clk) disable iff (sys_rst)
    flg0View[pief_pkg::PIEF_BIT_PINCHG] == portChangeFlags)
    else $error("pin-change summary mismatch");
  timer_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state.flg0[5] && !(wrStrobe && paddr == pief_pkg::PIEF_ADDR_FLG0)) |=> state.flg0[5])
    else $error("timer0 flag dropped");
  osc_sticky_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state.flg1[7] && !(wrStrobe && paddr == pief_pkg::PIEF_ADDR_FLG1)) |=> state.flg1[7])
    else $error("fail-safe flag dropped");
  unimpl_zero_a: assert property (@(posedge clk) disable iff (sys_rst)
    state.en6[7:5] == 3'h0 && state.en5[3] == 1'b0 && state.en8[7:6] == 2'h0)
    else $error("unimplemented enable bit set");
  en0_path_a: assert property (@(posedge clk) disable iff (sys_rst)
    (gieOn && en0Pend) |=> vectorReq)
    else $error("enable 0 source not vectored");
  periph_req_a: assert property (@(posedge clk) disable iff (sys_rst)
    (state.flg2[1] && state.en2[1]) |=> periphReq)
    else $error("peripheral request missing");
  pready_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    (psel && !penable) ##1 (psel && penable) |-> ##1 pready)
    else $error("pready late");

endmodule

// >>> src/pief_pkg.sv
// Package: register map, field positions and carriers for the enable and flag bank.
package pief_pkg;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [7:0] PIEF_ADDR_CTRL     = 8'h00;
  localparam logic [7:0] PIEF_ADDR_EN0      = 8'h04;
  localparam logic [7:0] PIEF_ADDR_EN1      = 8'h08;
  localparam logic [7:0] PIEF_ADDR_EN2      = 8'h0C;
  localparam logic [7:0] PIEF_ADDR_EN5      = 8'h10;
  localparam logic [7:0] PIEF_ADDR_EN6      = 8'h14;
  localparam logic [7:0] PIEF_ADDR_EN7      = 8'h18;
  localparam logic [7:0] PIEF_ADDR_EN8      = 8'h1C;
  localparam logic [7:0] PIEF_ADDR_FLG0     = 8'h20;
  localparam logic [7:0] PIEF_ADDR_FLG1     = 8'h24;
  localparam logic [7:0] PIEF_ADDR_FLG2     = 8'h28;
  localparam logic [7:0] PIEF_ADDR_IRQSTAT  = 8'h2C;
  localparam logic [7:0] PIEF_ADDR_IRQEN    = 8'h30;
  localparam logic [7:0] PIEF_ADDR_IRQCLR   = 8'h34;

  // ****************************************************************
  // Implemented-bit masks and field positions
  // ****************************************************************
  localparam logic [7:0] PIEF_MASK_CTRL = 8'hC0;
  localparam logic [7:0] PIEF_MASK_EN0  = 8'h31;
  localparam logic [7:0] PIEF_MASK_EN1  = 8'hC3;
  localparam logic [7:0] PIEF_MASK_EN2  = 8'h43;
  localparam logic [7:0] PIEF_MASK_EN5  = 8'hF7;
  localparam logic [7:0] PIEF_MASK_EN6  = 8'h1F;
  localparam logic [7:0] PIEF_MASK_EN7  = 8'hF7;
  localparam logic [7:0] PIEF_MASK_EN8  = 8'h3F;
  localparam logic [7:0] PIEF_MASK_FLG0 = 8'h31;
  localparam logic [7:0] PIEF_MASK_FLG1 = 8'hC3;
  localparam logic [7:0] PIEF_MASK_FLG2 = 8'h43;
  localparam int PIEF_BIT_GIE      = 7;
  localparam int PIEF_BIT_PERIPH_MASTER_ENABLE     = 6;
  localparam int PIEF_BIT_PINCHG   = 4;
  localparam logic [7:0] PIEF_RESET_VALUE = 8'h00;
  localparam logic [1:0] PIEF_EVT_REQ  = 2'h1;
  localparam logic [1:0] PIEF_EVT_VEC  = 2'h2;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] en0;
    logic [7:0] en1;
    logic [7:0] en2;
    logic [7:0] en5;
    logic [7:0] en6;
    logic [7:0] en7;
    logic [7:0] en8;
    logic [7:0] flg0;
    logic [7:0] flg1;
    logic [7:0] flg2;
    logic [1:0] irqStat;
    logic [1:0] irqEn;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        periphReq;
    logic        vectorReq;
    logic        irq;
  } pief_state_type;

  typedef struct packed {
    logic timer0Ovf;
    logic extEdge;
    logic oscFail;
    logic clkSwitchDone;
    logic convThreshold;
    logic convDone;
    logic zeroCross;
    logic comp2;
    logic comp1;
  } pief_events_type;

endpackage

// >>> testbench/pief_source.sv
// Event source model standing in for the timers, converters and comparators.
`timescale 1ns/1ps
module pief_source (
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  input  wire logic                      go,
  input  wire logic [3:0]                lag,
  input  wire pief_pkg::pief_events_type pattern,
  output pief_pkg::pief_events_type      events
);
  logic [3:0]                count;
  logic                      armed;
  pief_pkg::pief_events_type held;

  // Events are single-cycle strobes; a non-zero lag models a slow source.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      events <= '0;
      held   <= '0;
      armed  <= 1'b0;
      count  <= 4'h0;
    end else begin
      events <= '0;
      if (go) begin
        armed <= 1'b1;
        count <= lag;
        held  <= pattern;
      end else if (armed && count == 4'h0) begin
        events <= held;
        armed  <= 1'b0;
      end else if (armed) begin
        count <= count - 4'h1;
      end
    end
  end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the enable and flag bank.
`timescale 1ns/1ps
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin nMismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
  logic                      clk, sysRst, psel, penable, pwrite, pready, pslverr;
  logic                      go, portChg, periphReq, vectorReq, irq;
  logic [7:0]                paddr;
  logic [31:0]               pwdata, prdata, r;
  logic [3:0]                lag;
  logic [23:0]               ext;
  logic [32:0]               expd;
  logic [32:0]               q[$];
  pief_pkg::pief_events_type pattern, events, ev;
  int                        nMismatch, checksDone, seed, i;
  logic [7:0]                masks [4] = '{8'hF7, 8'h1F, 8'hF7, 8'h3F};

  pief_bank dut (.clk(clk), .sys_rst(sysRst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .events(events), .portChangeFlags(portChg), .extPeriphPending(ext),
    .periphReq(periphReq), .vectorReq(vectorReq), .irq(irq));
  pief_source src (.clk(clk), .sys_rst(sysRst), .go(go), .lag(lag), .pattern(pattern),
    .events(events));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************************************
  // Bus master, event driver and result watcher
  // ****************************************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    q.push_back(e);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 16);
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin nMismatch++; end_sim(); end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic err);
    apb(1'b1, a, d, {err, 32'h0});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask
  // The wait covers the source lag plus the flag and request stages.
  task automatic pulse(input pief_pkg::pief_events_type p, input logic [3:0] l);
    go <= 1'b1; pattern <= p; lag <= l;
    @(posedge clk);
    go <= 1'b0;
    repeat (int'(l) + 5) @(posedge clk);
  endtask
  task automatic end_sim();
    $display("mismatches=%0d checks=%0d", nMismatch, checksDone);
    if (nMismatch == 0 && checksDone > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) nMismatch++;
      else begin
        expd = q.pop_front();
        if (pwrite) `CHK(pslverr, expd[32])
        else `CHK({pslverr, prdata}, expd)
      end
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    sysRst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; go = 1'b0; lag = 4'h0; pattern = '0; portChg = 1'b0; ext = 24'h0;
    seed = 12; nMismatch = 0; checksDone = 0;
    repeat (3) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 14; i++) rd(8'(4 * i), 32'h0);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'hFF, 1'b1);
    for (i = 0; i < 8; i++) begin
      r = (i < 4) ? $random(seed) : 32'hFFFFFFFF;
      wr(pief_pkg::PIEF_ADDR_EN5 + 8'(4 * (i % 4)), r, 1'b0);
      rd(pief_pkg::PIEF_ADDR_EN5 + 8'(4 * (i % 4)), {24'h0, r[7:0] & masks[i % 4]});
    end
    pulse('1, 4'h3);
    `CHK({periphReq, vectorReq}, 2'b00)
    rd(pief_pkg::PIEF_ADDR_FLG0, 32'h21);
    rd(pief_pkg::PIEF_ADDR_FLG2, 32'h43);
    repeat (40) @(posedge clk);
    rd(pief_pkg::PIEF_ADDR_FLG1, 32'hC3);
    wr(pief_pkg::PIEF_ADDR_FLG1, 32'h03, 1'b0);
    rd(pief_pkg::PIEF_ADDR_FLG1, 32'h03);
    for (i = 0; i < 3; i++) wr(pief_pkg::PIEF_ADDR_FLG0 + 8'(4 * i), 32'h0, 1'b0);
    portChg <= 1'b1;
    repeat (3) @(posedge clk);
    wr(pief_pkg::PIEF_ADDR_FLG0, 32'h00, 1'b0);
    rd(pief_pkg::PIEF_ADDR_FLG0, 32'h10);
    portChg <= 1'b0;
    repeat (3) @(posedge clk);
    rd(pief_pkg::PIEF_ADDR_FLG0, 32'h00);
    wr(pief_pkg::PIEF_ADDR_EN1, 32'h80, 1'b0);
    wr(pief_pkg::PIEF_ADDR_CTRL, 32'h80, 1'b0);
    ev = '0;
    ev.oscFail = 1'b1;
    pulse(ev, 4'h0);
    `CHK({periphReq, vectorReq, irq}, 3'b100)
    rd(pief_pkg::PIEF_ADDR_IRQSTAT, 32'h1);
    wr(pief_pkg::PIEF_ADDR_CTRL, 32'hC0, 1'b0);
    repeat (3) @(posedge clk);
    `CHK(vectorReq, 1'b1)
    wr(pief_pkg::PIEF_ADDR_IRQEN, 32'h3, 1'b0);
    `CHK(irq, 1'b1)
    wr(pief_pkg::PIEF_ADDR_FLG1, 32'h0, 1'b0);
    repeat (3) @(posedge clk);
    `CHK({periphReq, vectorReq, irq}, 3'b001)
    wr(pief_pkg::PIEF_ADDR_IRQCLR, 32'h3, 1'b0);
    `CHK(irq, 1'b0)
    rd(pief_pkg::PIEF_ADDR_IRQSTAT, 32'h0);
    wr(pief_pkg::PIEF_ADDR_CTRL, 32'h80, 1'b0);
    wr(pief_pkg::PIEF_ADDR_EN0, 32'h20, 1'b0);
    ev = '0;
    ev.timer0Ovf = 1'b1;
    pulse(ev, 4'h1);
    `CHK(vectorReq, 1'b1)
    wr(pief_pkg::PIEF_ADDR_FLG0, 32'h0, 1'b0);
    ext <= 24'h1;
    repeat (3) @(posedge clk);
    `CHK(vectorReq, 1'b0)
    wr(pief_pkg::PIEF_ADDR_CTRL, 32'hC0, 1'b0);
    repeat (3) @(posedge clk);
    `CHK(vectorReq, 1'b1)
    end_sim();
  end
endmodule
